// *** logic/rt16_pkg.sv ***
// constants and types for the reduced 16-bit timer with capture
package rt16_pkg;
   // register byte addresses, one aligned word each
   localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
   localparam logic [7:0] ADDR_CNT_LO   = 8'h08;
   localparam logic [7:0] ADDR_CNT_HI   = 8'h0c;
   localparam logic [7:0] ADDR_CAPT_LO  = 8'h10;
   localparam logic [7:0] ADDR_CAPT_HI  = 8'h14;
   localparam logic [7:0] ADDR_FLAGS    = 8'h18;
   localparam logic [7:0] ADDR_MASKS    = 8'h1c;
   localparam logic [7:0] ADDR_POWER    = 8'h20;
   // counter landmarks
   localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hffff;
   localparam logic [15:0] TOP_8BIT     = 16'h00ff;
   localparam logic [15:0] TOP_9BIT     = 16'h01ff;
   localparam logic [15:0] TOP_10BIT    = 16'h03ff;
   // top selection, control a bits 2:0
   localparam logic [2:0] TOPM_MAX      = 3'h0;
   localparam logic [2:0] TOPM_8BIT     = 3'h1;
   localparam logic [2:0] TOPM_9BIT     = 3'h2;
   localparam logic [2:0] TOPM_10BIT    = 3'h3;
   localparam logic [2:0] TOPM_CAPT     = 3'h4;
   // clock source select, control b bits 2:0
   localparam logic [2:0] CS_NONE       = 3'h0;
   localparam logic [2:0] CS_DIV1       = 3'h1;
   localparam logic [2:0] CS_DIV8       = 3'h2;
   localparam logic [2:0] CS_DIV64      = 3'h3;
   localparam logic [2:0] CS_DIV256     = 3'h4;
   localparam logic [2:0] CS_DIV1024    = 3'h5;
   localparam logic [2:0] CS_EXT_FALL   = 3'h6;
   localparam logic [2:0] CS_EXT_RISE   = 3'h7;
   // prescaler
   localparam int          PRE_W        = 10;
   localparam logic [9:0]  DIV8_MASK    = 10'h007;
   localparam logic [9:0]  DIV64_MASK   = 10'h03f;
   localparam logic [9:0]  DIV256_MASK  = 10'h0ff;
   localparam logic [9:0]  DIV1024_MASK = 10'h3ff;
   // bit positions
   localparam int CTLB_EDGE_BIT = 6;
   localparam int CTLB_NC_BIT   = 7;
   localparam int FLAG_WRAP_BIT = 0;
   localparam int FLAG_CAPT_BIT = 1;
   localparam int PWR_OFF_BIT   = 0;
   // reset values
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   // noise canceler: equal samples needed
   localparam int NC_SAMPLES = 4;
   typedef enum logic [1:0] {
      RT16_BUS_IDLE   = 2'b00,
      RT16_BUS_ANSWER = 2'b01,
      RT16_BUS_REST   = 2'b11
   } rt16_bus_t;
endpackage

// *** logic/rt16_pin_sync.sv ***
// pin synchroniser with edge detector
`timescale 1ns/1ps
module rt16_pin_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } rt16_sync_t;

   rt16_sync_t sync_reg;
   rt16_sync_t sync_next;

   always_comb begin
      sync_next      = sync_reg;
      sync_next.s1   = pin;
      sync_next.s2   = sync_reg.s1;
      sync_next.prev = sync_reg.s2;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign level = sync_reg.s2;
   assign rise  = sync_reg.s2 & ~sync_reg.prev;
   assign fall  = ~sync_reg.s2 & sync_reg.prev;
endmodule

// *** logic/rt16_noise_filter.sv ***
// capture noise canceler: output follows only a stable input
`timescale 1ns/1ps
module rt16_noise_filter (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   input  wire logic din,
   output logic      dout
);
   localparam int HW = rt16_pkg::NC_SAMPLES - 1;

   typedef struct packed {
      logic [HW-1:0] hist;
      logic          out;
   } rt16_filt_t;

   rt16_filt_t filt_reg;
   rt16_filt_t filt_next;

   always_comb begin
      filt_next      = filt_reg;
      filt_next.hist = {filt_reg.hist[HW-2:0], din};
      if (!enable) begin
         filt_next.out = din;
      end else if (din && (&filt_reg.hist)) begin
         filt_next.out = 1'b1;
      end else if (!din && !(|filt_reg.hist)) begin
         filt_next.out = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_reg <= '0;
      end else begin
         filt_reg <= filt_next;
      end
   end

   assign dout = filt_reg.out;
endmodule

// *** logic/rt16_timer.sv ***
// reduced 16-bit timer with input capture behind an apb slave
// Overview of operation
// - one shared high-byte latch for all pairs
// - low-byte write loads latch plus low byte, capture pair only in capture-top mode
// - low-byte read copies high byte to latch
// - zero count flags bottom
// - all ones count flags maximum
// - top is fixed value or capture register
// - counter clears after reaching top
// - no clock source means counter holds
// - tick from prescaler or external pin
// - select logic picks source and edge
// - power-off bit stops prescaler, counting and capture; bus registers stay accessible
// - capture edge stores count in capture, except in capture-top mode
// - optional filter removes capture pin spikes
// - wrap and capture flags in flag bank
// - mask bits gate each request
// - control registers need no latch sequence
// - select seven rising, six falling edges
// - external edge updates count after sync
// - software count write beats count or clear
// - capture flag sets with capture, clears
`timescale 1ns/1ps
module rt16_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_count_pin,
   input  wire logic        capture_pin,
   input  wire logic        capture_ack,
   input  wire logic        wrap_ack,
   output logic             wrap_irq,
   output logic             capture_irq,
   output logic             count_at_bottom,
   output logic             count_at_max
);
   typedef struct packed {
      rt16_pkg::rt16_bus_t          bus;
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
      logic [7:0]                   ctrl_a;
      logic [7:0]                   ctrl_b;
      logic [15:0]                  count;
      logic [15:0]                  capt;
      logic [7:0]                   hi_latch;
      logic                         wrap_f;
      logic                         capt_f;
      logic                         wrap_m;
      logic                         capt_m;
      logic                         pwr_off;
      logic [rt16_pkg::PRE_W-1:0]   pre;
      logic                         capt_prev;
      logic                         wrap_irq;
      logic                         capt_irq;
      logic                         bottom;
      logic                         max;
   } rt16_state_t;

   rt16_state_t st_reg;
   rt16_state_t st_next;

   logic        ext_rise;
   logic        ext_fall;
   logic        capt_sync;
   logic        capt_filt;
   logic [2:0]  cs;
   logic        tick;
   logic [15:0] top;
   logic        at_top;
   logic        capt_event;
   logic        mapped;
   logic        wr_done;
   logic [7:0]  wbyte;

   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         rt16_pkg::ADDR_CTRL_A,
         rt16_pkg::ADDR_CTRL_B,
         rt16_pkg::ADDR_CNT_LO,
         rt16_pkg::ADDR_CNT_HI,
         rt16_pkg::ADDR_CAPT_LO,
         rt16_pkg::ADDR_CAPT_HI,
         rt16_pkg::ADDR_FLAGS,
         rt16_pkg::ADDR_MASKS,
         rt16_pkg::ADDR_POWER: is_mapped = 1'b1;
         default:              is_mapped = 1'b0;
      endcase
   endfunction

   // top of the count sequence per mode
   function automatic logic [15:0] top_of(input logic [2:0] mode, input logic [15:0] capt);
      case (mode)
         rt16_pkg::TOPM_8BIT:  top_of = rt16_pkg::TOP_8BIT;
         rt16_pkg::TOPM_9BIT:  top_of = rt16_pkg::TOP_9BIT;
         rt16_pkg::TOPM_10BIT: top_of = rt16_pkg::TOP_10BIT;
         rt16_pkg::TOPM_CAPT:  top_of = capt;
         default:              top_of = rt16_pkg::CNT_MAX;
      endcase
   endfunction

   // internal prescaled tick for a clock select value
   function automatic logic int_tick(input logic [2:0] sel, input logic [9:0] pre);
      case (sel)
         rt16_pkg::CS_DIV1:    int_tick = 1'b1;
         rt16_pkg::CS_DIV8:    int_tick = (pre & rt16_pkg::DIV8_MASK) == 10'h000;
         rt16_pkg::CS_DIV64:   int_tick = (pre & rt16_pkg::DIV64_MASK) == 10'h000;
         rt16_pkg::CS_DIV256:  int_tick = (pre & rt16_pkg::DIV256_MASK) == 10'h000;
         rt16_pkg::CS_DIV1024: int_tick = (pre & rt16_pkg::DIV1024_MASK) == 10'h000;
         default:              int_tick = 1'b0;
      endcase
   endfunction

   rt16_pin_sync u_ext_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (ext_count_pin),
      .level   (),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );

   rt16_pin_sync u_capt_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (capture_pin),
      .level   (capt_sync),
      .rise    (),
      .fall    ()
   );

   rt16_noise_filter u_capt_filter (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (st_reg.ctrl_b[rt16_pkg::CTLB_NC_BIT]),
      .din     (capt_sync),
      .dout    (capt_filt)
   );

   assign cs = st_reg.ctrl_b[2:0];

   // timer tick: none when stopped or powered off
   assign tick = !st_reg.pwr_off && (
                    int_tick(cs, st_reg.pre) ||
                    (cs == rt16_pkg::CS_EXT_RISE && ext_rise) ||
                    (cs == rt16_pkg::CS_EXT_FALL && ext_fall));

   assign top    = top_of(st_reg.ctrl_a[2:0], st_reg.capt);
   assign at_top = st_reg.count == top;

   // edge of the filtered capture input, polarity from control b
   assign capt_event = !st_reg.pwr_off &&
                       (st_reg.ctrl_b[rt16_pkg::CTLB_EDGE_BIT] ?
                        (capt_filt && !st_reg.capt_prev) :
                        (!capt_filt && st_reg.capt_prev));

   assign mapped  = is_mapped(paddr);
   assign wr_done = (st_reg.bus == rt16_pkg::RT16_BUS_ANSWER) && psel && penable &&
                    pwrite && !st_reg.pslverr;
   assign wbyte   = pwdata[7:0];

   always_comb begin
      st_next           = st_reg;
      st_next.capt_prev = capt_filt;
      st_next.pre       = st_reg.pwr_off ? '0 : st_reg.pre + 10'h001;

      // count and auto-reload
      if (tick) begin
         if (at_top) begin
            st_next.count = rt16_pkg::CNT_BOTTOM;
         end else begin
            st_next.count = st_reg.count + 16'h0001;
         end
      end

      // capture; the register holds the top in capture-top mode
      if (capt_event && st_reg.ctrl_a[2:0] != rt16_pkg::TOPM_CAPT) begin
         st_next.capt = st_reg.count;
      end

      // interrupt acknowledge from the processor
      if (capture_ack) begin
         st_next.capt_f = 1'b0;
      end
      if (wrap_ack) begin
         st_next.wrap_f = 1'b0;
      end

      // apb: answer one cycle after the access phase starts
      case (st_reg.bus)
         rt16_pkg::RT16_BUS_IDLE: begin
            if (psel && penable) begin
               st_next.bus     = rt16_pkg::RT16_BUS_ANSWER;
               st_next.pready  = 1'b1;
               st_next.pslverr = !mapped;
               st_next.prdata  = 32'h0000_0000;
               if (!pwrite) begin
                  case (paddr)
                     rt16_pkg::ADDR_CTRL_A: st_next.prdata[7:0] = st_reg.ctrl_a;
                     rt16_pkg::ADDR_CTRL_B: st_next.prdata[7:0] = st_reg.ctrl_b;
                     rt16_pkg::ADDR_CNT_LO: begin
                        st_next.prdata[7:0] = st_reg.count[7:0];
                        st_next.hi_latch    = st_reg.count[15:8];
                     end
                     rt16_pkg::ADDR_CAPT_LO: begin
                        st_next.prdata[7:0] = st_reg.capt[7:0];
                        st_next.hi_latch    = st_reg.capt[15:8];
                     end
                     rt16_pkg::ADDR_CNT_HI,
                     rt16_pkg::ADDR_CAPT_HI: st_next.prdata[7:0] = st_reg.hi_latch;
                     rt16_pkg::ADDR_FLAGS: begin
                        st_next.prdata[rt16_pkg::FLAG_WRAP_BIT] = st_reg.wrap_f;
                        st_next.prdata[rt16_pkg::FLAG_CAPT_BIT] = st_reg.capt_f;
                     end
                     rt16_pkg::ADDR_MASKS: begin
                        st_next.prdata[rt16_pkg::FLAG_WRAP_BIT] = st_reg.wrap_m;
                        st_next.prdata[rt16_pkg::FLAG_CAPT_BIT] = st_reg.capt_m;
                     end
                     rt16_pkg::ADDR_POWER: st_next.prdata[rt16_pkg::PWR_OFF_BIT] = st_reg.pwr_off;
                     default: st_next.prdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         rt16_pkg::RT16_BUS_ANSWER: begin
            st_next.bus     = rt16_pkg::RT16_BUS_REST;
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            if (wr_done) begin
               case (paddr)
                  rt16_pkg::ADDR_CTRL_A: st_next.ctrl_a = wbyte;
                  rt16_pkg::ADDR_CTRL_B: st_next.ctrl_b = wbyte;
                  rt16_pkg::ADDR_CNT_HI,
                  rt16_pkg::ADDR_CAPT_HI: st_next.hi_latch = wbyte;
                  rt16_pkg::ADDR_CNT_LO: st_next.count = {st_reg.hi_latch, wbyte};
                  rt16_pkg::ADDR_CAPT_LO: begin
                     if (st_reg.ctrl_a[2:0] == rt16_pkg::TOPM_CAPT) begin
                        st_next.capt = {st_reg.hi_latch, wbyte};
                     end
                  end
                  rt16_pkg::ADDR_FLAGS: begin
                     if (wbyte[rt16_pkg::FLAG_WRAP_BIT]) begin
                        st_next.wrap_f = 1'b0;
                     end
                     if (wbyte[rt16_pkg::FLAG_CAPT_BIT]) begin
                        st_next.capt_f = 1'b0;
                     end
                  end
                  rt16_pkg::ADDR_MASKS: begin
                     st_next.wrap_m = wbyte[rt16_pkg::FLAG_WRAP_BIT];
                     st_next.capt_m = wbyte[rt16_pkg::FLAG_CAPT_BIT];
                  end
                  rt16_pkg::ADDR_POWER: st_next.pwr_off = wbyte[rt16_pkg::PWR_OFF_BIT];
                  default: st_next.pwr_off = st_reg.pwr_off;
               endcase
            end
         end
         rt16_pkg::RT16_BUS_REST: begin
            st_next.bus = rt16_pkg::RT16_BUS_IDLE;
         end
         default: begin
            st_next.bus    = rt16_pkg::RT16_BUS_IDLE;
            st_next.pready = 1'b0;
         end
      endcase

      // hardware sets win over any clear in the same cycle
      if (tick && at_top) begin
         st_next.wrap_f = 1'b1;
      end
      if (capt_event) begin
         st_next.capt_f = 1'b1;
      end

      st_next.wrap_irq = st_next.wrap_f && st_next.wrap_m;
      st_next.capt_irq = st_next.capt_f && st_next.capt_m;
      st_next.bottom   = st_next.count == rt16_pkg::CNT_BOTTOM;
      st_next.max      = st_next.count == rt16_pkg::CNT_MAX;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg           <= '0;
         st_reg.bus       <= rt16_pkg::RT16_BUS_IDLE;
         st_reg.ctrl_a    <= rt16_pkg::RST_BYTE;
         st_reg.ctrl_b    <= rt16_pkg::RST_BYTE;
         st_reg.hi_latch  <= rt16_pkg::RST_BYTE;
         st_reg.count     <= rt16_pkg::RST_WORD;
         st_reg.capt      <= rt16_pkg::RST_WORD;
         st_reg.bottom    <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata          = st_reg.prdata;
   assign pready          = st_reg.pready;
   assign pslverr         = st_reg.pslverr;
   assign wrap_irq        = st_reg.wrap_irq;
   assign capture_irq     = st_reg.capt_irq;
   assign count_at_bottom = st_reg.bottom;
   assign count_at_max    = st_reg.max;
endmodule

// *** tb/rt16_timer_asserts.sv ***
// concurrent checks on the timer's bus and status ports
`timescale 1ns/1ps
module rt16_timer_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ext_count_pin,
   input wire logic        capture_pin,
   input wire logic        capture_ack,
   input wire logic        wrap_ack,
   input wire logic        wrap_irq,
   input wire logic        capture_irq,
   input wire logic        count_at_bottom,
   input wire logic        count_at_max
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ACCESS_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside an answer");
   AST_ERR_ADDR: assert property (pready |-> pslverr == !(paddr <= rt16_pkg::ADDR_POWER && paddr[1:0] == 2'b00))
      else $error("pslverr does not match address map");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   AST_ERR_NO_DATA: assert property (pready && pslverr |-> prdata == 32'h00000000)
      else $error("unmapped access returned data");
   AST_MAX_LEAVE: assert property ($fell(count_at_max) |-> count_at_bottom || $past(pready && pwrite) || $past(pready && pwrite, 2))
      else $error("count left all-ones without wrap or write");
   AST_EXCL: assert property (!(count_at_bottom && count_at_max))
      else $error("bottom and max together");
   AST_WRAP_FALL: assert property ($fell(wrap_irq) |-> $past(wrap_ack || (pready && pwrite)))
      else $error("wrap request dropped without cause");
   AST_CAPT_FALL: assert property ($fell(capture_irq) |-> $past(capture_ack || (pready && pwrite)))
      else $error("capture request dropped without cause");
endmodule
bind rt16_timer rt16_timer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .ext_count_pin, .capture_pin, .capture_ack, .wrap_ack, .wrap_irq, .capture_irq, .count_at_bottom,
   .count_at_max);

// *** tb/rt16_cpu_model.sv ***
// processor-side apb master with interrupt acknowledge
`timescale 1ns/1ps
module rt16_cpu_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             capture_ack,
   output logic             wrap_ack
);
   logic [31:0] rd_data = 32'h00000000;
   logic        rd_err = 1'b0;
   initial begin
      {psel, penable, pwrite, capture_ack, wrap_ack} <= 5'h00;
      paddr <= 8'hff;
      pwdata <= 32'hffffffff;
   end
   // entered just after a rising edge; ends one idle edge after the answer
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h000000, data};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~addr;
      pwdata <= ~{24'h000000, data};
      @(posedge pclk);
   endtask
   // whole pairs only, so no other access can disturb the shared latch
   task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
      xfer(1'b1, lo + 8'h04, v[15:8]);
      xfer(1'b1, lo, v[7:0]);
   endtask
   task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
      xfer(1'b0, lo, 8'h00);
      v[7:0] = rd_data[7:0];
      xfer(1'b0, lo + 8'h04, 8'h00);
      v[15:8] = rd_data[7:0];
   endtask
   task automatic ack(input logic capt);
      if (capt) capture_ack <= 1'b1; else wrap_ack <= 1'b1;
      @(posedge pclk);
      {capture_ack, wrap_ack} <= 2'b00;
      @(posedge pclk);
   endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the reduced 16-bit timer
`timescale 1ns/1ps
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ext_count_pin = 1'b0;
   logic        capture_pin = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, capture_ack, wrap_ack;
   logic        wrap_irq, capture_irq, count_at_bottom, count_at_max;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] v;
   int          n_errors = 0;
   int          n_checks = 0;
   int          i, k;
   // top per top mode 0..4; mode 4 uses the value captured earlier
   logic [15:0] tops [5] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff, 16'h1234};
   int          divs [5] = '{1, 8, 64, 256, 1024};
   // {wr, addr, wdata, err, expected byte}
   logic [31:0] rows [34] = '{32'h0_00_00_000, 32'h0_04_00_000, 32'h0_08_00_000, 32'h0_10_00_000, 32'h0_18_00_000,
      32'h0_1c_00_000, 32'h0_20_00_000, 32'h1_00_03_000, 32'h0_00_00_003, 32'h1_04_c0_000, 32'h0_04_00_0c0,
      32'h1_1c_03_000, 32'h0_1c_00_003, 32'h1_0c_12_000, 32'h1_08_34_000, 32'h0_08_00_034, 32'h0_0c_00_012,
      32'h1_14_56_000, 32'h1_10_78_000, 32'h0_10_00_000, 32'h0_14_00_000, 32'h1_0c_ab_000, 32'h0_10_00_000,
      32'h1_08_cd_000, 32'h0_08_00_0cd, 32'h0_0c_00_000, 32'h0_24_00_100, 32'h1_02_55_100, 32'h0_00_00_003,
      32'h1_00_04_000, 32'h1_14_01_000, 32'h1_10_02_000, 32'h0_10_00_002, 32'h0_14_00_001};
   always #20 pclk = ~pclk;
   rt16_cpu_model cpu (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_ack,
      .wrap_ack);
   rt16_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ext_count_pin, .capture_pin, .capture_ack, .wrap_ack, .wrap_irq, .capture_irq, .count_at_bottom,
      .count_at_max);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors=%0d checks=%0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         ext_count_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_count_pin <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({count_at_bottom, wrap_irq, capture_irq, count_at_max}, 32'h8);
      for (i = 0; i < 34; i++) begin
         cpu.xfer(rows[i][28], rows[i][27:20], rows[i][19:12]);
         chk(cpu.rd_data, {24'h000000, rows[i][7:0]});
         chk({31'h0, cpu.rd_err}, {31'h0, rows[i][8]});
      end
      // capture with filter on, counter held
      cpu.xfer(1'b1, 8'h00, 8'h00);
      cpu.wr16(8'h08, 16'h1234);
      capture_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      capture_pin <= 1'b0;
      repeat (12) @(posedge pclk);
      chk(capture_irq, 1'b0);
      capture_pin <= 1'b1;
      for (k = 0; k < 20 && capture_irq !== 1'b1; k++) @(posedge pclk);
      chk(capture_irq, 1'b1);
      cpu.rd16(8'h10, v);
      chk(v, 16'h1234);
      cpu.xfer(1'b0, 8'h18, 8'h00);
      chk(cpu.rd_data, 32'h2);
      cpu.xfer(1'b1, 8'h18, 8'h02);
      chk(capture_irq, 1'b0);
      // falling edge, filter off, cleared by acknowledge
      cpu.xfer(1'b1, 8'h04, 8'h00);
      cpu.xfer(1'b1, 8'h18, 8'h03);
      capture_pin <= 1'b0;
      for (k = 0; k < 20 && capture_irq !== 1'b1; k++) @(posedge pclk);
      chk(capture_irq, 1'b1);
      cpu.ack(1'b1);
      chk(capture_irq, 1'b0);
      // wrap at the 8-bit top, mask gating
      cpu.xfer(1'b1, 8'h00, 8'h01);
      cpu.wr16(8'h08, 16'h00fd);
      cpu.xfer(1'b1, 8'h04, 8'h01);
      for (k = 0; k < 40 && wrap_irq !== 1'b1; k++) @(posedge pclk);
      chk(wrap_irq, 1'b1);
      cpu.xfer(1'b1, 8'h04, 8'h00);
      cpu.rd16(8'h08, v);
      chk(v < 16'h0040, 1'b1);
      cpu.xfer(1'b1, 8'h1c, 8'h00);
      chk(wrap_irq, 1'b0);
      cpu.xfer(1'b1, 8'h1c, 8'h03);
      chk(wrap_irq, 1'b1);
      cpu.xfer(1'b1, 8'h18, 8'h01);
      chk(wrap_irq, 1'b0);
      // every top mode wraps exactly at its top, flag cleared by acknowledge
      foreach (tops[j]) begin
         cpu.xfer(1'b1, 8'h00, 8'(j));
         cpu.wr16(8'h08, tops[j] - 16'h0001);
         cpu.xfer(1'b1, 8'h04, 8'h01);
         @(posedge pclk);
         chk(wrap_irq, 1'b0);
         @(posedge pclk);
         chk({wrap_irq, count_at_bottom}, 2'b11);
         cpu.xfer(1'b1, 8'h04, 8'h00);
         cpu.ack(1'b0);
         chk(wrap_irq, 1'b0);
      end
      // landmarks
      cpu.xfer(1'b1, 8'h00, 8'h00);
      cpu.wr16(8'h08, 16'hffff);
      @(posedge pclk);
      chk({count_at_max, count_at_bottom}, 2'b10);
      cpu.wr16(8'h08, 16'h0000);
      @(posedge pclk);
      chk({count_at_max, count_at_bottom}, 2'b01);
      // external rising edges, then falling edges
      cpu.xfer(1'b1, 8'h04, 8'h07);
      ext_count_pin <= 1'b1;
      for (k = 0; k < 8 && count_at_bottom === 1'b1; k++) @(posedge pclk);
      chk(k, 4);
      repeat (4) @(posedge pclk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      pulses(2);
      cpu.xfer(1'b1, 8'h04, 8'h00);
      cpu.rd16(8'h08, v);
      chk(v, 16'h0003);
      cpu.xfer(1'b1, 8'h04, 8'h06);
      pulses(3);
      cpu.xfer(1'b1, 8'h04, 8'h00);
      cpu.rd16(8'h08, v);
      chk(v, 16'h0006);
      // power-off freezes counting
      cpu.wr16(8'h08, 16'h0000);
      cpu.xfer(1'b1, 8'h20, 8'h01);
      cpu.xfer(1'b1, 8'h04, 8'h01);
      repeat (20) @(posedge pclk);
      cpu.xfer(1'b1, 8'h04, 8'h00);
      cpu.rd16(8'h08, v);
      chk(v, 16'h0000);
      cpu.xfer(1'b1, 8'h20, 8'h00);
      cpu.xfer(1'b1, 8'h04, 8'h01);
      cpu.xfer(1'b1, 8'h04, 8'h00);
      cpu.rd16(8'h08, v);
      chk(v != 16'h0000, 1'b1);
      // internal divisors, each over exactly 1024 edges
      for (i = 0; i < 5; i++) begin
         cpu.wr16(8'h08, 16'h0000);
         cpu.xfer(1'b1, 8'h04, 8'(i + 1));
         repeat (1020) @(posedge pclk);
         cpu.xfer(1'b1, 8'h04, 8'h00);
         cpu.rd16(8'h08, v);
         chk(v, 1024 / divs[i]);
      end
      // a count write beats the tick of the same cycle
      cpu.xfer(1'b1, 8'h04, 8'h01);
      cpu.wr16(8'h08, 16'hffff);
      chk(count_at_max, 1'b1);
      // reset in mid-run with the counter running
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({count_at_bottom, wrap_irq, capture_irq, count_at_max}, 32'h8);
      cpu.xfer(1'b0, 8'h04, 8'h00);
      chk(cpu.rd_data, 32'h0);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      close_out();
   end
endmodule
